// File: hw/period_match_timer8_cfg.svh
// Register offsets, field positions, reset values and timing counts of the period match timer
`ifndef PERIOD_MATCH_TIMER8_CFG_SVH
`define PERIOD_MATCH_TIMER8_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the AXI4-Lite bus
// ----------------------------------------------------------------------------
`define PMT_CONTROL_OFFSET     8'h00
`define PMT_COUNT_OFFSET       8'h04
`define PMT_PERIOD_OFFSET      8'h08
`define PMT_STATUS_OFFSET      8'h0c
`define PMT_MASK_OFFSET        8'h10
`define PMT_SHIFT_SEL_OFFSET   8'h14

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PMT_CONTROL_RESET      8'h00
`define PMT_COUNT_RESET        8'h00
`define PMT_PERIOD_RESET       8'hff

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PMT_PRESCALE_LSB       0
`define PMT_TIMER_ON_BIT       2
`define PMT_POSTSCALE_LSB      3
`define PMT_UNUSED_BIT         7
`define PMT_MATCH_FLAG_BIT     0
`define PMT_SHIFT_SEL_BIT      0

// ----------------------------------------------------------------------------
// Timing counts and bus answers
// ----------------------------------------------------------------------------
`define PMT_INSTR_DIV          4
`define PMT_PRESCALE_TERM1     4'h0
`define PMT_PRESCALE_TERM4     4'h3
`define PMT_PRESCALE_TERM16    4'hf
`define PMT_RESP_OKAY          2'h0
`define PMT_RESP_SLVERR        2'h2

`endif

// File: hw/period_match_timer8_pkg.sv
// Types shared by the period match timer modules
package period_match_timer8_pkg;

  // ----------------------------------------------------------------------------
  // Control register layout
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic       unused;            // Always reads zero
    logic [3:0] postscale_select;  // Matches per flag event minus one
    logic       timer_on;          // Counting enable
    logic [1:0] prescale_select;   // Clock division code
  } timer_control_type;

  // ----------------------------------------------------------------------------
  // Bus channel states, Gray coded along the path
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CHAN_IDLE = 2'b00,
    CHAN_RESP = 2'b01
  } chan_state_type;

endpackage

// File: hw/instr_prescaler.sv
// Instruction clock divider and selectable 1/4/16 prescaler
`timescale 1ns/100ps
`include "period_match_timer8_cfg.svh"
module instr_prescaler
  import period_match_timer8_pkg::*;
#(
  parameter int INSTR_DIV = `PMT_INSTR_DIV
) (
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       clear_i,
  input  wire logic       run_i,
  input  wire logic [1:0] select_i,
  output logic            tick_o
);

  localparam int PW = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;

  // Divider must fit its phase counter
  if (INSTR_DIV < 2) begin : g_bad_div
    $error("INSTR_DIV must be at least 2");
  end

  logic [PW-1:0] phase_q;      // Oscillator phase within an instruction cycle
  logic [3:0]    count_q;      // Prescale counter of instruction ticks
  logic          tick_q;       // Registered scaled tick
  wire           instr_tick;   // One pulse per instruction cycle
  wire  [3:0]    term;         // Terminal count for the selected division

  assign instr_tick = (phase_q == PW'(INSTR_DIV - 1));
  assign term       = select_i[1] ? `PMT_PRESCALE_TERM16 :
                      (select_i[0] ? `PMT_PRESCALE_TERM4 : `PMT_PRESCALE_TERM1);
  assign tick_o     = tick_q;

  // Free running phase; cleared only by reset so instruction timing stays steady
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      phase_q <= '0;
    end else begin
      phase_q <= instr_tick ? '0 : phase_q + 1'b1;
    end
  end

  // Prescale counter, cleared by count or control writes and reset
  always_ff @(posedge clock_i) begin
    if (reset_i || clear_i) begin
      count_q <= 4'h0;
      tick_q  <= 1'b0;
    end else begin
      tick_q <= run_i && instr_tick && (count_q >= term);
      if (run_i && instr_tick) begin
        count_q <= (count_q >= term) ? 4'h0 : count_q + 4'h1;
      end
    end
  end

endmodule // instr_prescaler

// File: hw/match_postscaler.sv
// Four-bit postscaler that turns match pulses into flag events
`timescale 1ns/100ps
module match_postscaler
  import period_match_timer8_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       clear_i,
  input  wire logic       match_i,
  input  wire logic [3:0] select_i,
  output logic            event_o
);

  logic [3:0] count_q;  // Matches seen since last event
  logic       event_q;  // Registered event pulse

  assign event_o = event_q;

  // Count matches; event after select plus one of them
  always_ff @(posedge clock_i) begin
    if (reset_i || clear_i) begin
      count_q <= 4'h0;
      event_q <= 1'b0;
    end else begin
      event_q <= match_i && (count_q >= select_i);
      if (match_i) begin
        count_q <= (count_q >= select_i) ? 4'h0 : count_q + 4'h1;
      end
    end
  end

endmodule // match_postscaler

// File: hw/period_match_timer8.sv
// Eight-bit period match timer with prescaler, postscaler and AXI4-Lite registers
//
// Behaviour
// - Count up per prescaled instruction tick
// - Prescale codes: 1, 4, 16
// - Count equal period gives match pulse
// - Match zeroes count, advances postscaler
// - Reset: count zero, period all ones
// - Scalers clear on count or control writes and reset
// - Control write keeps count value
// - Postscale: field plus one matches
// - Control bit two runs the timer
// - Control bit seven reads zero
// - Postscaler event sets latched flag
// - Flag reaches interrupt only when enabled
// - Unscaled match goes to capture/compare
// - Match selectable as serial shift clock
// - Count and period freely read/write
`timescale 1ns/100ps
`include "period_match_timer8_cfg.svh"
module period_match_timer8
  import period_match_timer8_pkg::*;
#(
  parameter int ADDR_WIDTH = 8,
  parameter int INSTR_DIV  = `PMT_INSTR_DIV
) (
  input  wire logic                  clock_i,
  input  wire logic                  reset_i,
  // AXI4-Lite write address
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  // AXI4-Lite read address
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  // Timer outputs
  output logic                       match_pulse_o,
  output logic                       shift_clock_o,
  output logic                       irq_o
);

  // ----------------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------------
  // Decode slices the low eight address bits, so a narrower bus cannot serve
  if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_bad_addr
    $error("ADDR_WIDTH must be 8 to 32");
  end

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  // Write channel capture
  chan_state_type          wr_state_q;      // Idle or answering a write
  logic                    aw_held_q;       // Write address taken
  logic                    w_held_q;        // Write data taken
  logic [ADDR_WIDTH-1:0]   aw_addr_q;       // Captured write address
  logic [31:0]             w_data_q;        // Captured write data
  logic [3:0]              w_strb_q;        // Captured byte strobes
  logic                    awready_q;       // Address channel ready
  logic                    wready_q;        // Data channel ready
  logic                    bvalid_q;        // Response pending
  logic [1:0]              bresp_q;         // Response code
  // Read channel
  chan_state_type          rd_state_q;      // Idle or answering a read
  logic                    arready_q;       // Read address ready
  logic                    rvalid_q;        // Read data pending
  logic [31:0]             rdata_q;         // Read data
  logic [1:0]              rresp_q;         // Read response code
  // Timer state
  timer_control_type       control_q;       // Control register
  logic [7:0]              count_q;         // Current count
  logic [7:0]              period_q;        // Period value
  logic                    flag_q;          // Latched match flag
  logic                    mask_q;          // Match interrupt enable
  logic                    shift_sel_q;     // Match drives serial shift clock
  logic                    match_q;         // Registered match pulse
  logic                    shift_clk_q;     // Registered shift clock
  logic                    irq_q;           // Registered interrupt level

  // ----------------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------------
  wire        aw_take    = s_axi_awvalid_i && awready_q;
  wire        w_take     = s_axi_wvalid_i && wready_q;
  // Both halves present and no answer outstanding: apply the write now
  wire        wr_fire    = aw_held_q && w_held_q && (wr_state_q == CHAN_IDLE);
  wire [7:0]  wr_off     = aw_addr_q[7:0];
  wire        lane0      = w_strb_q[0];
  wire [7:0]  wr_byte    = w_data_q[7:0];
  wire        hit_ctrl   = (wr_off == `PMT_CONTROL_OFFSET);
  wire        hit_count  = (wr_off == `PMT_COUNT_OFFSET);
  wire        hit_period = (wr_off == `PMT_PERIOD_OFFSET);
  wire        hit_status = (wr_off == `PMT_STATUS_OFFSET);
  wire        hit_mask   = (wr_off == `PMT_MASK_OFFSET);
  wire        hit_shift  = (wr_off == `PMT_SHIFT_SEL_OFFSET);
  wire        wr_mapped  = hit_ctrl || hit_count || hit_period || hit_status || hit_mask || hit_shift;
  wire        wr_ctrl    = wr_fire && hit_ctrl && lane0;
  wire        wr_count   = wr_fire && hit_count && lane0;
  wire        wr_period  = wr_fire && hit_period && lane0;
  wire        wr_status  = wr_fire && hit_status && lane0;
  wire        wr_mask    = wr_fire && hit_mask && lane0;
  wire        wr_shift   = wr_fire && hit_shift && lane0;
  // Scalers restart on any count or control write
  wire        scaler_clr = wr_ctrl || wr_count;

  // ----------------------------------------------------------------------------
  // Scalers and match
  // ----------------------------------------------------------------------------
  wire        pre_tick;                                   // Prescaled tick
  wire        post_event;                                 // Postscaler output
  wire        at_period = (count_q == period_q);
  wire        match_now = pre_tick && control_q.timer_on && at_period;

  instr_prescaler #(
    .INSTR_DIV (INSTR_DIV)
  ) u_prescaler (
    .clock_i  (clock_i),
    .reset_i  (reset_i),
    .clear_i  (scaler_clr),
    .run_i    (control_q.timer_on),
    .select_i (control_q.prescale_select),
    .tick_o   (pre_tick)
  );

  match_postscaler u_postscaler (
    .clock_i  (clock_i),
    .reset_i  (reset_i),
    .clear_i  (scaler_clr),
    .match_i  (match_now),
    .select_i (control_q.postscale_select),
    .event_o  (post_event)
  );

  // ----------------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------------
  wire [7:0]  rd_off     = s_axi_araddr_i[7:0];
  wire        ar_take    = s_axi_arvalid_i && arready_q;
  wire [7:0]  ctrl_view  = {1'b0, control_q[6:0]};
  wire        rd_mapped  = (rd_off == `PMT_CONTROL_OFFSET) || (rd_off == `PMT_COUNT_OFFSET)
                        || (rd_off == `PMT_PERIOD_OFFSET) || (rd_off == `PMT_STATUS_OFFSET)
                        || (rd_off == `PMT_MASK_OFFSET) || (rd_off == `PMT_SHIFT_SEL_OFFSET);
  wire [7:0]  rd_byte    = (rd_off == `PMT_CONTROL_OFFSET) ? ctrl_view :
                           (rd_off == `PMT_COUNT_OFFSET)   ? count_q :
                           (rd_off == `PMT_PERIOD_OFFSET)  ? period_q :
                           (rd_off == `PMT_STATUS_OFFSET)  ? {7'h00, flag_q} :
                           (rd_off == `PMT_MASK_OFFSET)    ? {7'h00, mask_q} :
                           (rd_off == `PMT_SHIFT_SEL_OFFSET) ? {7'h00, shift_sel_q} : 8'h00;

  // ----------------------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------------------
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o  = wready_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;
  assign match_pulse_o   = match_q;
  assign shift_clock_o   = shift_clk_q;
  assign irq_o           = irq_q;

  // ----------------------------------------------------------------------------
  // Write address and data capture, either order
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
    end else begin
      // Take the address and hold off further ones until answered
      if (aw_take) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_i;
        awready_q <= 1'b0;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      // Take the data likewise
      if (w_take) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
        wready_q <= 1'b0;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
      // Reopen both channels once the response is accepted
      if (bvalid_q && s_axi_bready_i) begin
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wr_state_q <= CHAN_IDLE;
      bvalid_q   <= 1'b0;
      bresp_q    <= `PMT_RESP_OKAY;
    end else begin
      case (wr_state_q)
        CHAN_IDLE: begin
          // Unmapped offsets answer with a slave error
          if (wr_fire) begin
            wr_state_q <= CHAN_RESP;
            bvalid_q   <= 1'b1;
            bresp_q    <= wr_mapped ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
          end
        end
        CHAN_RESP: begin
          // Hold the answer until the master takes it
          if (s_axi_bready_i) begin
            wr_state_q <= CHAN_IDLE;
            bvalid_q   <= 1'b0;
          end
        end
        default: begin
          wr_state_q <= CHAN_IDLE;
          bvalid_q   <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rd_state_q <= CHAN_IDLE;
      arready_q  <= 1'b1;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= `PMT_RESP_OKAY;
    end else begin
      case (rd_state_q)
        CHAN_IDLE: begin
          // Sample the register state in the taking cycle
          if (ar_take) begin
            rd_state_q <= CHAN_RESP;
            arready_q  <= 1'b0;
            rvalid_q   <= 1'b1;
            rdata_q    <= {24'h00_0000, rd_byte};
            rresp_q    <= rd_mapped ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
          end
        end
        CHAN_RESP: begin
          if (s_axi_rready_i) begin
            rd_state_q <= CHAN_IDLE;
            arready_q  <= 1'b1;
            rvalid_q   <= 1'b0;
          end
        end
        default: begin
          rd_state_q <= CHAN_IDLE;
          arready_q  <= 1'b1;
          rvalid_q   <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Control and configuration registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      control_q   <= `PMT_CONTROL_RESET;
      period_q    <= `PMT_PERIOD_RESET;
      mask_q      <= 1'b0;
      shift_sel_q <= 1'b0;
    end else begin
      // Bit seven is never stored
      if (wr_ctrl) begin
        control_q <= {1'b0, wr_byte[6:0]};
      end
      if (wr_period) begin
        period_q <= wr_byte;
      end
      if (wr_mask) begin
        mask_q <= wr_byte[`PMT_MATCH_FLAG_BIT];
      end
      if (wr_shift) begin
        shift_sel_q <= wr_byte[`PMT_SHIFT_SEL_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Count register
  // ----------------------------------------------------------------------------
  // A software write beats a tick in the same cycle; control writes leave it
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      count_q <= `PMT_COUNT_RESET;
    end else if (wr_count) begin
      count_q <= wr_byte;
    end else if (pre_tick && control_q.timer_on) begin
      count_q <= at_period ? 8'h00 : count_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------------------
  // Match outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      match_q     <= 1'b0;
      shift_clk_q <= 1'b0;
    end else begin
      match_q     <= match_now;
      shift_clk_q <= match_now && shift_sel_q;
    end
  end

  // ----------------------------------------------------------------------------
  // Match flag and interrupt
  // ----------------------------------------------------------------------------
  // A new event in the clearing cycle wins, so no event is lost
  wire flag_clr = wr_status && wr_byte[`PMT_MATCH_FLAG_BIT];
  wire flag_d   = post_event || (flag_q && !flag_clr);

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      flag_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      flag_q <= flag_d;
      irq_q  <= flag_q && mask_q;
    end
  end

endmodule // period_match_timer8

// File: test/period_match_timer8_checker.sv
// Port assertions for the period match timer
`timescale 1ns/100ps
module period_match_timer8_checker (
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        match_pulse_o,
  input wire logic        shift_clock_o,
  input wire logic        irq_o
);
  // ---------------------------------------------------------------------------
  // Properties, one clock domain
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // Ticks are four clocks apart, so matches can never crowd closer
  AST_MATCH_GAP: assert property (match_pulse_o |=> !match_pulse_o [*3]) else $error("match too soon");
  AST_SHIFT_MATCH: assert property (shift_clock_o |-> match_pulse_o) else $error("shift without match");
  AST_RESET_QUIET: assert property ($fell(reset_i) |-> !match_pulse_o && !irq_o && !s_axi_bvalid_o)
    else $error("outputs live after reset");
  AST_B_DONE: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o) else $error("bvalid stuck");
  AST_R_DONE: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o)
    else $error("rvalid stuck");
  AST_R_UPPER: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0) else $error("upper read bits");
  AST_AW_BUSY: assert property (s_axi_bvalid_o |-> !s_axi_awready_o) else $error("aw ready while busy");
  AST_AR_BUSY: assert property (s_axi_rvalid_o |-> !s_axi_arready_o) else $error("ar ready while busy");
endmodule // period_match_timer8_checker

bind period_match_timer8 period_match_timer8_checker i_period_match_timer8_checker (
  .clock_i(clock_i), .reset_i(reset_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .match_pulse_o(match_pulse_o),
  .shift_clock_o(shift_clock_o), .irq_o(irq_o));

// File: test/period_match_timer8_bench.sv
// Self-checking bench for the period match timer
`timescale 1ns/100ps
`include "period_match_timer8_cfg.svh"
module period_match_timer8_bench import period_match_timer8_pkg::*; ;
  logic        clock_i = 1'b0;          // 250 MHz clock
  logic        reset_i = 1'b1;          // Held for eight cycles
  logic [7:0]  awaddr  = 8'h00;         // Write address
  logic [7:0]  araddr  = 8'h00;         // Read address
  logic [31:0] wdata   = 32'h0;         // Write data
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid, match, shift, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int          err_total = 0, comparisons = 0;

  period_match_timer8 i_period_match_timer8 (.clock_i(clock_i), .reset_i(reset_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .match_pulse_o(match), .shift_clock_o(shift), .irq_o(irq));

  always #2 clock_i = ~clock_i;

  // ---------------------------------------------------------------------------
  // Verdict, compare and bus tasks
  // ---------------------------------------------------------------------------
  task close_out;
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Write: both channels offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `PMT_RESP_OKAY);
    int n;
    @(posedge clock_i);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 40 && !bvalid; n++) begin
      @(posedge clock_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    if (n == 40) begin cmp("write timeout", 0, 1); close_out; end
    bready <= 1'b0;
    cmp("bresp", r, bresp);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = `PMT_RESP_OKAY);
    int n;
    @(posedge clock_i);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 40 && !rvalid; n++) begin
      @(posedge clock_i);
      if (arready) arvalid <= 1'b0;
    end
    if (n == 40) begin cmp("read timeout", 0, 1); close_out; end
    rready <= 1'b0;
    cmp("rdata", e, rdata);
    cmp("rresp", r, rresp);
  endtask
  // Waits for the next match pulse, bounded
  task wait_match(output int n);
    for (n = 1; n < 2000; n++) begin
      @(posedge clock_i);
      if (match === 1'b1) break;
    end
    if (n == 2000) begin cmp("match timeout", 0, 1); close_out; end
  endtask
  function automatic logic [31:0] ctl(input logic [3:0] p, input logic [1:0] s);
    timer_control_type c;
    c = '{unused: 1'b0, postscale_select: p, timer_on: 1'b1, prescale_select: s};
    return {24'h0, c};
  endfunction

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task reset_values;
    rd(`PMT_CONTROL_OFFSET, 32'h0);
    rd(`PMT_COUNT_OFFSET, 32'h0);
    rd(`PMT_PERIOD_OFFSET, 32'hff);
    rd(8'h18, 32'h0, `PMT_RESP_SLVERR);
    wr(8'h18, 32'h1, `PMT_RESP_SLVERR);
  endtask
  task reg_access;
    wr(`PMT_CONTROL_OFFSET, 32'hff);
    rd(`PMT_CONTROL_OFFSET, 32'h7f);
    wr(`PMT_CONTROL_OFFSET, 32'h0);
    wr(`PMT_COUNT_OFFSET, 32'h15a);
    rd(`PMT_COUNT_OFFSET, 32'h5a);
    wr(`PMT_PERIOD_OFFSET, 32'h77);
    rd(`PMT_PERIOD_OFFSET, 32'h77);
    wr(`PMT_CONTROL_OFFSET, 32'h78);
    repeat (100) @(posedge clock_i);
    rd(`PMT_COUNT_OFFSET, 32'h5a);
  endtask
  // Period three, every prescale code: gap is four counts of 4*div clocks
  task rates;
    int n, c;
    wr(`PMT_PERIOD_OFFSET, 32'h3);
    wr(`PMT_SHIFT_SEL_OFFSET, 32'h1);
    for (c = 0; c < 4; c++) begin
      wr(`PMT_CONTROL_OFFSET, ctl(4'h0, c[1:0]));
      wait_match(n);
      cmp("shift", 1, shift);
      wait_match(n);
      cmp("gap", (c == 0) ? 16 : (c == 1) ? 64 : 256, n);
    end
    wr(`PMT_SHIFT_SEL_OFFSET, 32'h0);
    wait_match(n);
    cmp("shift off", 0, shift);
  endtask
  // Three matches per flag, then masking, stickiness and clearing
  task flags;
    int n, i;
    wr(`PMT_CONTROL_OFFSET, 32'h0);
    wr(`PMT_COUNT_OFFSET, 32'h0);
    wr(`PMT_STATUS_OFFSET, 32'h1);
    wr(`PMT_CONTROL_OFFSET, ctl(4'h2, 2'h0));
    repeat (2) wait_match(n);
    wr(`PMT_COUNT_OFFSET, 32'h0);
    for (i = 1; i < 4; i++) begin
      wait_match(n);
      rd(`PMT_STATUS_OFFSET, (i == 3) ? 32'h1 : 32'h0);
    end
    cmp("irq masked", 0, irq);
    wr(`PMT_MASK_OFFSET, 32'h1);
    repeat (3) @(posedge clock_i);
    cmp("irq", 1, irq);
    wr(`PMT_STATUS_OFFSET, 32'h0);
    repeat (4) wait_match(n);
    rd(`PMT_STATUS_OFFSET, 32'h1);
    wr(`PMT_CONTROL_OFFSET, 32'h0);
    wr(`PMT_STATUS_OFFSET, 32'h1);
    rd(`PMT_STATUS_OFFSET, 32'h0);
    cmp("irq cleared", 0, irq);
  endtask

  initial begin
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    reset_values();
    reg_access();
    rates();
    flags();
    close_out();
  end
endmodule // period_match_timer8_bench
